// File: inc/dancer_defs.vh
`ifndef DANCER_DEFS_VH
`define DANCER_DEFS_VH
// Register byte offsets.
`define A_ACTION    8'h00
`define A_UPPER     8'h04
`define A_LOWER     8'h08
`define A_SETPT     8'h0C
`define A_INTYPE    8'h10
`define A_INSEL0    8'h14
`define A_OUTSEL0   8'h30
`define A_STATUS    8'h3C
`define A_MEAS      8'h40
`define A_NETBITS   8'h44
// Reset values and codes.
`define ACTION_RST  16'h0000
`define DANCER_LO   16'h0028
`define DANCER_HI   16'h002B
`define SENTINEL    16'h270F
`define SETPT_HALF  10'h1F4
`define FULL_SCALE  16'h03E8
`define IN_CODE_DSEL 8'h0E
`define OUT_LOWER   8'h0E
`define OUT_UPPER   8'h0F
`define OUT_DIR     8'h10
`define OUT_PID     8'h2F
`define OUT_NEG     8'h64
`define TYPE_4_20MA 2'h0
`define TYPE_0_5V   2'h1
`define TYPE_0_10V  2'h2
// Raw converter counts (12-bit, full scale 10 V or 20 mA).
`define RAW_4MA     12'h0333
`define RAW_5V      12'h07FF
`define RAW_FULL    12'h0FFF
`define N_IN        7
`define N_OUT       3
`endif

// File: verif/dancer_control_io_select_tb.sv
/* Self-checking bench for the dancer selection block.
   Assumes the block, its defines header and the roller model are compiled first. */
`timescale 1ns/100ps
`include "dancer_defs.vh"
module dancer_control_io_select_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic forward_rotation = 1'b0;
    logic reverse_rotation = 1'b0;
    logic [6:0] pin_lvl = 7'h00;
    logic [11:0] raw_lvl = 12'h000;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, active;
    logic [6:0] pins;
    logic [11:0] raw;
    logic [2:0] oterm;
    logic [9:0] setp, meas;
    int err_total = 0;
    int n_tests = 0;
    logic [15:0] act_tab [7] = '{16'h0000, 16'h0027, 16'h0028, 16'h0029, 16'h002A,
                                 16'h002B, 16'h002C};
    logic exp_tab [7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [1:0] typ_tab [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    logic [11:0] raw_tab [6] = '{12'h333, 12'h999, 12'h400, 12'hFFF, 12'h800, 12'h000};
    logic [9:0] mv_tab [6] = '{10'h000, 10'h1F4, 10'h1F4, 10'h3E8, 10'h1F4, 10'h000};
    initial begin
        forever #25 clk = ~clk;
    end
    roller_model model (.clk(clk), .pin_lvl(pin_lvl), .raw_lvl(raw_lvl), .pins(pins),
        .raw(raw));
    dancer_control_io_select dut (.I_CLOCK(clk), .I_ARST_N(arst_n), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
        .I_HSEL(1'b1), .I_HREADY(hreadyout), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout),
        .O_HRESP(hresp), .I_TERMINALS(pins), .I_FORWARD_ROTATION(forward_rotation),
        .I_REVERSE_ROTATION(reverse_rotation), .I_TERMINAL4_ENABLE_INPUT(1'b0), .I_ROLLER_RAW(raw),
        .O_OUTPUT_TERMINALS(oterm), .O_DANCER_ACTIVE(active), .O_SET_POINT(setp),
        .O_MEASURED(meas));
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Pin inputs pass a synchroniser, so outputs are looked at well after it.
    task automatic settle;
        repeat (8) @(posedge clk);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            xfer(1'b1, `A_ACTION, {16'h0000, act_tab[i]});
            settle;
            chk(active, exp_tab[i]);
        end
        for (int i = 0; i < 6; i++) begin
            xfer(1'b1, `A_INTYPE, {30'h0000_0000, typ_tab[i]});
            raw_lvl <= raw_tab[i];
            settle;
            chk(meas, mv_tab[i]);
        end
        chk(setp, 32'h0000_01F4);
        xfer(1'b1, `A_SETPT, 32'h0000_00FA);
        settle;
        chk(setp, 32'h0000_00FA);
        xfer(1'b1, `A_ACTION, 32'h0000_0028);
        xfer(1'b1, `A_INSEL0, 32'h0000_000E);
        settle;
        chk(active, 1'b0);
        pin_lvl <= 7'h01;
        settle;
        chk(active, 1'b1);
        pin_lvl <= 7'h00;
        settle;
        chk(active, 1'b0);
        xfer(1'b1, `A_NETBITS, 32'h0000_0001);
        settle;
        chk(active, 1'b1);
        xfer(1'b1, `A_OUTSEL0, 32'h0000_002F);
        settle;
        chk(oterm[0], 1'b1);
        xfer(1'b1, `A_OUTSEL0, 32'h0000_0093);
        settle;
        chk(oterm[0], 1'b0);
        xfer(1'b1, `A_OUTSEL0 + 8'h04, 32'h0000_0010);
        forward_rotation <= 1'b1;
        settle;
        chk(oterm[1], 1'b1);
        forward_rotation <= 1'b0;
        reverse_rotation <= 1'b1;
        settle;
        chk(oterm[1], 1'b0);
        xfer(1'b1, `A_INTYPE, 32'h0000_0002);
        xfer(1'b1, `A_OUTSEL0 + 8'h08, 32'h0000_000F);
        raw_lvl <= 12'hFFF;
        settle;
        chk(oterm[2], 1'b0);
        xfer(1'b1, `A_UPPER, 32'h0000_01F4);
        settle;
        chk(oterm[2], 1'b1);
        xfer(1'b1, `A_OUTSEL0 + 8'h08, 32'h0000_000E);
        raw_lvl <= 12'h000;
        settle;
        chk(oterm[2], 1'b0);
        xfer(1'b1, `A_LOWER, 32'h0000_01F4);
        settle;
        chk(oterm[2], 1'b1);
        xfer(1'b1, `A_OUTSEL0 + 8'h08, 32'h0000_0072);
        settle;
        chk(oterm[2], 1'b0);
        xfer(1'b0, `A_ACTION, 32'h0000_0000);
        chk(rd, 32'h0000_0028);
        chk(hresp, 1'b0);
        xfer(1'b0, 8'h80, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        arst_n <= 1'b0;
        @(posedge clk);
        chk(active, 1'b0);
        arst_n <= 1'b1;
        settle;
        chk(setp, 32'h0000_01F4);
        finish_test;
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        finish_test;
    end
endmodule
bind dancer_control_io_select dancer_io_checker chk_i (.I_CLOCK(I_CLOCK),
    .I_ARST_N(I_ARST_N), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
    .I_HWDATA(I_HWDATA), .I_HSEL(I_HSEL), .I_HREADY(I_HREADY), .O_HRDATA(O_HRDATA),
    .I_FORWARD_ROTATION(I_FORWARD_ROTATION), .I_REVERSE_ROTATION(I_REVERSE_ROTATION),
    .O_OUTPUT_TERMINALS(O_OUTPUT_TERMINALS), .O_DANCER_ACTIVE(O_DANCER_ACTIVE),
    .O_SET_POINT(O_SET_POINT), .O_MEASURED(O_MEASURED));

// File: verif/dancer_io_checker.sv
/* Assertions on the dancer selection block's ports.
   Assumes binding to the block, zero-wait writes stored after the data phase
   and read data standing two cycles after the address phase. */
`timescale 1ns/100ps
module dancer_io_checker (
    input wire I_CLOCK,
    input wire I_ARST_N,
    input wire [31:0] I_HADDR,
    input wire [1:0] I_HTRANS,
    input wire I_HWRITE,
    input wire [31:0] I_HWDATA,
    input wire I_HSEL,
    input wire I_HREADY,
    input wire [31:0] O_HRDATA,
    input wire I_FORWARD_ROTATION,
    input wire I_REVERSE_ROTATION,
    input wire [2:0] O_OUTPUT_TERMINALS,
    input wire O_DANCER_ACTIVE,
    input wire [9:0] O_SET_POINT,
    input wire [9:0] O_MEASURED
);
    logic [31:0] shadow [0:17];
    logic [4:0] wa;
    logic wp;
    // A mirror of the parameters lets outputs be tied to what was written.
    always @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            wp <= 1'b0;
            wa <= 5'h00;
            for (int k = 0; k < 18; k++) begin
                shadow[k] <= (k > 0 && k < 4) ? 32'h0000_270F : 32'h0000_0000;
            end
        end else begin
            if (wp && wa < 5'h12) begin
                shadow[wa] <= I_HWDATA;
            end
            wp <= I_HSEL && I_HREADY && I_HTRANS[1] && I_HWRITE;
            wa <= I_HADDR[6:2];
        end
    end
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_ARST_N);
    sequence s_hole_read;
        I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE && I_HADDR[31:8] == 24'h00_0000 &&
        I_HADDR[7:0] >= 8'h48;
    endsequence
    sequence s_pid_held(code);
        (shadow[12] == code && $stable(O_DANCER_ACTIVE))[*3];
    endsequence
    a_hole_read: assert property (s_hole_read |-> ##2 O_HRDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_action_off: assert property (
        (shadow[0] < 32'h0000_0028 || shadow[0] > 32'h0000_002B)[*3] |-> !O_DANCER_ACTIVE)
        else $error("dancer active outside action range");
    a_setpt_half: assert property (
        (shadow[3] == 32'h0000_270F)[*3] |-> O_SET_POINT == 10'h1F4)
        else $error("sentinel set point not half");
    a_meas_limit: assert property (
        O_MEASURED <= 10'h3E8) else $error("measured above full scale");
    a_pid_flag: assert property (
        s_pid_held(32'h0000_002F) |-> O_OUTPUT_TERMINALS[0] == O_DANCER_ACTIVE)
        else $error("pid flag differs from active");
    a_pid_neg: assert property (
        s_pid_held(32'h0000_0093) |-> O_OUTPUT_TERMINALS[0] != O_DANCER_ACTIVE)
        else $error("inverted pid flag not inverted");
    a_dir_flag: assert property (
        (shadow[13] == 32'h0000_0010 && I_FORWARD_ROTATION && !I_REVERSE_ROTATION)[*8]
        |-> O_OUTPUT_TERMINALS[1]) else $error("direction flag off in forward");
    a_upper_off: assert property (
        (shadow[14] == 32'h0000_000F && shadow[1] == 32'h0000_270F)[*3]
        |-> !O_OUTPUT_TERMINALS[2]) else $error("upper flag with sentinel limit");
    a_lower_off: assert property (
        (shadow[14] == 32'h0000_000E && shadow[2] == 32'h0000_270F)[*3]
        |-> !O_OUTPUT_TERMINALS[2]) else $error("lower flag with sentinel limit");
endmodule

// File: verif/roller_model.sv
/* Roller position detector and external controller pins.
   Assumes the bench sets levels; they reach the block one clock later. */
`timescale 1ns/100ps
module roller_model (
    input wire logic clk,
    input wire logic [6:0] pin_lvl,
    input wire logic [11:0] raw_lvl,
    output logic [6:0] pins,
    output logic [11:0] raw
);
    // The converter sample is taken on the block's own clock.
    always @(posedge clk) begin
        pins <= pin_lvl;
        raw <= raw_lvl;
    end
endmodule

// File: verilog/dancer_control_io_select.v
/*
 Dancer control signal selection: enable, set point, roller measurement scaling,
 and mapped limit, direction and PID-active output flags, with an AHB-Lite slave.
 Assumes a 20 MHz clock, a 12-bit converter sample on the same clock and the
 terminal and direction inputs coming asynchronously from pins.
*/
// How it works
// - Actions 40 to 43 enable dancer control
// - Input selector code 14 maps dancer select
// - Unmapped select: action value alone enables
// - Action 0 or select off bypasses
// - Set point parameter, measurement from terminal
// - Input type scales measurement to tenths of a percent
// - Upper flag above limit, codes 15/115
// - Lower flag below limit, codes 14/114
// - Direction flag on only in forward
// - PID flag on while dancer active
// - Codes 100 and above invert output
// - Terminal-4-enable input not required
// - Select off leaves dancer, keeps frequency
// - Set point 9999 means fifty percent
`timescale 1ns/100ps
`include "dancer_defs.vh"
module dancer_control_io_select (
    input wire I_CLOCK,
    input wire I_ARST_N,
    input wire [31:0] I_HADDR,
    input wire [1:0] I_HTRANS,
    input wire I_HWRITE,
    input wire [2:0] I_HSIZE,
    input wire [31:0] I_HWDATA,
    input wire I_HSEL,
    input wire I_HREADY,
    output reg [31:0] O_HRDATA,
    output reg O_HREADYOUT,
    output reg O_HRESP,
    input wire [6:0] I_TERMINALS,
    input wire I_FORWARD_ROTATION,
    input wire I_REVERSE_ROTATION,
    input wire I_TERMINAL4_ENABLE_INPUT,
    input wire [11:0] I_ROLLER_RAW,
    output reg [2:0] O_OUTPUT_TERMINALS,
    output reg O_DANCER_ACTIVE,
    output reg [9:0] O_SET_POINT,
    output reg [9:0] O_MEASURED
);
    // Parameter registers, written over the bus.
    reg [15:0] action_q;
    reg [15:0] upper_q;
    reg [15:0] lower_q;
    reg [15:0] setpt_q;
    reg [1:0] intype_q;
    reg [7:0] insel_q [0:6];
    reg [7:0] outsel_q [0:2];
    reg [6:0] netbits_q;
    reg [8:0] s1_q;
    reg [8:0] s2_q;
    reg [8:0] s3_q;
    reg [8:0] pins_q;
    reg upper_flag_q;
    reg lower_flag_q;
    reg [31:0] rdata_d;
    // Bus state: data-phase address and direction.
    reg [7:0] wa_q;
    reg wr_q;
    reg [7:0] ra_q;
    reg rd_q;
    wire take = I_HSEL & I_HREADY & I_HTRANS[1];
    integer k;
    integer j;
    integer m;

    // Three-stage pin synchroniser; a change counts once stages two and three agree.
    always @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            s1_q <= 9'h000;
            s2_q <= 9'h000;
            s3_q <= 9'h000;
            pins_q <= 9'h000;
        end else begin
            s1_q <= {I_REVERSE_ROTATION, I_FORWARD_ROTATION, I_TERMINALS};
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (k = 0; k < 9; k = k + 1) begin
                if (s2_q[k] == s3_q[k]) begin
                    pins_q[k] <= s3_q[k];
                end
            end
        end
    end

    wire [6:0] term_on = pins_q[6:0] | netbits_q;
    wire forward_rotation = pins_q[7] & ~pins_q[8];

    reg sel_mapped;
    reg sel_on;
    always @* begin
        sel_mapped = 1'b0;
        sel_on = 1'b0;
        for (j = 0; j < `N_IN; j = j + 1) begin
            if (insel_q[j] == `IN_CODE_DSEL) begin
                sel_mapped = 1'b1;
                sel_on = sel_on | term_on[j];
            end
        end
    end

    wire dancer_mode = (action_q >= `DANCER_LO) && (action_q <= `DANCER_HI);
    // leave on select off
    // An unmapped select input leaves the action value alone in charge.
    wire dancer_on = dancer_mode & (~sel_mapped | sel_on);

    // enable input ignored
    // The divide is combinational and is the slowest path at 20 MHz.
    reg [23:0] num;
    reg [23:0] den;
    reg [23:0] quot;
    reg [11:0] span;
    reg [11:0] base;
    reg [9:0] meas_d;
    always @* begin
        base = 12'h000;
        span = `RAW_FULL;
        case (intype_q)
            `TYPE_4_20MA: begin
                base = `RAW_4MA;
                span = `RAW_FULL - `RAW_4MA;
            end
            `TYPE_0_5V: begin
                span = `RAW_5V;
            end
            default: begin
                span = `RAW_FULL;
            end
        endcase
        if (I_ROLLER_RAW <= base) begin
            num = 24'h00_0000;
        end else begin
            num = {12'h000, I_ROLLER_RAW - base} * {8'h00, `FULL_SCALE};
        end
        den = {12'h000, span};
        quot = num / den;
        // A 0-5 V sample above 5 V would pass full scale, so it is held there.
        if (quot > {8'h00, `FULL_SCALE}) begin
            quot = {8'h00, `FULL_SCALE};
        end
        meas_d = quot[9:0];
    end

    wire [9:0] setpt_d = (setpt_q == `SENTINEL) ? `SETPT_HALF : setpt_q[9:0];

    always @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_DANCER_ACTIVE <= 1'b0;
            O_SET_POINT <= 10'h000;
            O_MEASURED <= 10'h000;
            upper_flag_q <= 1'b0;
            lower_flag_q <= 1'b0;
        end else begin
            O_DANCER_ACTIVE <= dancer_on;
            O_SET_POINT <= setpt_d;
            O_MEASURED <= meas_d;
            // Limits are compared in tenths of a percent, the unit of the measurement.
            // upper limit
            upper_flag_q <= dancer_mode && (upper_q != `SENTINEL) &&
                            ({6'h00, meas_d} > upper_q);
            lower_flag_q <= dancer_mode && (lower_q != `SENTINEL) &&
                            ({6'h00, meas_d} < lower_q);
        end
    end

    wire [2:0] out_lvl;
    genvar g;
    generate
        for (g = 0; g < `N_OUT; g = g + 1) begin : outs
            // Codes 100 and above pick the same flag with the level inverted.
            wire neg = outsel_q[g] >= `OUT_NEG;
            wire [7:0] fn = neg ? outsel_q[g] - `OUT_NEG : outsel_q[g];
            reg lvl;
            always @* begin
                case (fn)
                    `OUT_UPPER: lvl = upper_flag_q;
                    `OUT_LOWER: lvl = lower_flag_q;
                    `OUT_DIR: lvl = forward_rotation;
                    `OUT_PID: lvl = O_DANCER_ACTIVE;
                    default: lvl = 1'b0;
                endcase
            end
            assign out_lvl[g] = lvl ^ neg;
        end
    endgenerate

    // The PID flag follows the registered active output, one cycle behind it.
    always @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_OUTPUT_TERMINALS <= 3'h0;
        end else begin
            O_OUTPUT_TERMINALS <= out_lvl;
        end
    end

    // Selector windows: seven input words, then three output words.
    wire ra_in = (ra_q >= `A_INSEL0) && (ra_q < `A_INSEL0 + 8'h1C);
    wire ra_out = (ra_q >= `A_OUTSEL0) && (ra_q < `A_OUTSEL0 + 8'h0C);
    wire wa_in = (wa_q >= `A_INSEL0) && (wa_q < `A_INSEL0 + 8'h1C);
    wire wa_out = (wa_q >= `A_OUTSEL0) && (wa_q < `A_OUTSEL0 + 8'h0C);
    wire [7:0] ra_in_off = ra_q - `A_INSEL0;
    wire [7:0] ra_out_off = ra_q - `A_OUTSEL0;
    wire [7:0] wa_in_off = wa_q - `A_INSEL0;
    wire [7:0] wa_out_off = wa_q - `A_OUTSEL0;

    always @* begin
        rdata_d = 32'h0000_0000;
        case (ra_q)
            `A_ACTION: rdata_d = {16'h0000, action_q};
            `A_UPPER: rdata_d = {16'h0000, upper_q};
            `A_LOWER: rdata_d = {16'h0000, lower_q};
            `A_SETPT: rdata_d = {16'h0000, setpt_q};
            `A_INTYPE: rdata_d = {30'h0000_0000, intype_q};
            `A_STATUS: rdata_d = {27'h000_0000, O_OUTPUT_TERMINALS, lower_flag_q, upper_flag_q} |
                                 {22'h00_0000, O_DANCER_ACTIVE, 9'h000};
            `A_MEAS: rdata_d = {22'h00_0000, O_MEASURED};
            `A_NETBITS: rdata_d = {25'h000_0000, netbits_q};
            default: begin
                // Unmapped offsets read as zero.
                if (ra_in) begin
                    rdata_d = {24'h00_0000, insel_q[ra_in_off[4:2]]};
                end else if (ra_out) begin
                    rdata_d = {24'h00_0000, outsel_q[ra_out_off[3:2]]};
                end
            end
        endcase
    end

    // Writes land at the end of a zero-wait data phase; a read inserts one wait
    // state so that its data leaves a flip-flop. Only address bits 7:0 are decoded.
    always @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            wa_q <= 8'h00;
            ra_q <= 8'h00;
            O_HRDATA <= 32'h0000_0000;
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
            action_q <= `ACTION_RST;
            upper_q <= `SENTINEL;
            lower_q <= `SENTINEL;
            setpt_q <= `SENTINEL;
            intype_q <= `TYPE_4_20MA;
            netbits_q <= 7'h00;
            for (m = 0; m < `N_IN; m = m + 1) begin
                insel_q[m] <= 8'h00;
            end
            for (m = 0; m < `N_OUT; m = m + 1) begin
                outsel_q[m] <= 8'h00;
            end
        end else begin
            wr_q <= take & I_HWRITE;
            rd_q <= take & ~I_HWRITE;
            wa_q <= I_HADDR[7:0];
            if (take & ~I_HWRITE) begin
                ra_q <= I_HADDR[7:0];
            end
            O_HREADYOUT <= ~(take & ~I_HWRITE);
            if (rd_q) begin
                O_HRDATA <= rdata_d;
            end
            if (wr_q) begin
                case (wa_q)
                    `A_ACTION: action_q <= I_HWDATA[15:0];
                    `A_UPPER: upper_q <= I_HWDATA[15:0];
                    `A_LOWER: lower_q <= I_HWDATA[15:0];
                    `A_SETPT: setpt_q <= I_HWDATA[15:0];
                    `A_INTYPE: intype_q <= I_HWDATA[1:0];
                    `A_NETBITS: netbits_q <= I_HWDATA[6:0];
                    default: begin
                        if (wa_in) begin
                            insel_q[wa_in_off[4:2]] <= I_HWDATA[7:0];
                        end else if (wa_out) begin
                            outsel_q[wa_out_off[3:2]] <= I_HWDATA[7:0];
                        end
                    end
                endcase
            end
        end
    end

endmodule
